// file: rtl/rcts_pkg.sv
package rcts_pkg;

  // ---------------------------------------------------------------
  // timing and sizes
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned ABORT_MS      = 7;
  localparam int unsigned ABORT_CYCLES  = CLK_HZ / 1000 * ABORT_MS;
  localparam int unsigned FRAME_RATE    = 30;
  localparam int unsigned FRAME_CYCLES  = CLK_HZ / FRAME_RATE;
  localparam int unsigned EXPOSE_CYCLES = 1_000_000;
  localparam int unsigned READ_CYCLES   = 2_000_000;
  localparam int unsigned NUM_PORTS     = 4;
  localparam int unsigned NUM_STREAMS   = 3;
  localparam int unsigned PIX_W         = 16;
  localparam int unsigned FIFO_DEPTH    = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic             sof;
    logic             eof;
    logic             trig;
  } rcts_word_t;

  typedef enum logic [1:0] {
    RCTS_IDLE,
    RCTS_EXPOSE,
    RCTS_READ
  } rcts_cap_t;

endpackage

// file: rtl/rcts_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module rcts_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // flush drops partial frames still waiting
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/rcts_seq.sv
`timescale 1ns/1ns
`default_nettype none
module rcts_seq #(
  parameter int unsigned NPORT    = rcts_pkg::NUM_PORTS,
  parameter int unsigned NSTREAM  = rcts_pkg::NUM_STREAMS,
  parameter int unsigned ABORT_N  = rcts_pkg::ABORT_CYCLES,
  parameter int unsigned FRAME_N  = rcts_pkg::FRAME_CYCLES,
  parameter int unsigned EXPOSE_N = rcts_pkg::EXPOSE_CYCLES,
  parameter int unsigned READ_N   = rcts_pkg::READ_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [NPORT-1:0]             trig_pin,
  input  wire logic [NPORT-1:0]             trig_en,
  input  wire logic [NPORT-1:0]             trig_invert,
  input  wire logic [NSTREAM-1:0]           stream_en,
  input  wire logic [rcts_pkg::PIX_W-1:0]   sensor_pix,
  output logic                              expose_start,
  output logic                              abort_active,
  output logic                              frame_drop,
  output logic      [NSTREAM-1:0]           out_valid,
  output var  rcts_pkg::rcts_word_t         out_word,
  input  wire logic                         out_ready,
  output logic                              overflow
);
  if (NPORT < 1 || NSTREAM < 1 || ABORT_N < 2 || FRAME_N < 2 ||
      EXPOSE_N < 1 || READ_N < 2 ||
      EXPOSE_N + READ_N > FRAME_N) begin : g_bad_params
    $error("bad sequencer parameters");
  end

  // ---------------------------------------------------------------
  // trigger inputs
  // ---------------------------------------------------------------
  logic [NPORT-1:0] sync1;
  logic [NPORT-1:0] sync2;
  logic [NPORT-1:0] prev;
  logic [NPORT-1:0] hit;
  logic             trig_pulse;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= trig_pin;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_edge
      // rising edge unless inverted, then falling edge
      assign hit[gi] = trig_en[gi] && (trig_invert[gi] ?
                       (prev[gi] && !sync2[gi]) :
                       (!prev[gi] && sync2[gi]));
    end
  endgenerate
  // one pulse per edge; a held level never re-fires
  assign trig_pulse = |hit;

  // ---------------------------------------------------------------
  // abort interval and frame timing
  // ---------------------------------------------------------------
  logic [31:0] abort_cnt;
  logic [31:0] frame_cnt;
  logic        abort_end;
  logic        frame_tick;
  logic        trig_pend;

  assign abort_end  = abort_active && abort_cnt == 32'(ABORT_N - 1);
  assign frame_tick = !abort_active && frame_cnt == 32'(FRAME_N - 1);

  // a new trigger during the abort restarts the 7 ms interval
  always_ff @(posedge clk) begin
    if (rst) begin
      abort_active <= 1'b0;
      abort_cnt    <= '0;
    end else if (trig_pulse) begin
      abort_active <= 1'b1;
      abort_cnt    <= '0;
    end else if (abort_end) begin
      abort_active <= 1'b0;
    end else if (abort_active) begin
      abort_cnt <= abort_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || abort_active) begin
      frame_cnt <= '0;
    end else if (frame_tick) begin
      frame_cnt <= '0;
    end else begin
      frame_cnt <= frame_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // capture engine
  // ---------------------------------------------------------------
  rcts_pkg::rcts_cap_t cap;
  logic [31:0]         cap_cnt;
  logic                cap_trig;
  logic                start;
  logic                rd_last;
  logic                push_valid;
  logic                push_ready;
  logic                flush;
  rcts_pkg::rcts_word_t push_word;

  assign start   = abort_end || frame_tick;
  assign rd_last = cap == rcts_pkg::RCTS_READ && cap_cnt == 32'(READ_N - 1);
  // abort kills the capture and purges its queued words everywhere
  assign flush   = trig_pulse;
  assign push_valid = cap == rcts_pkg::RCTS_READ;

  always_ff @(posedge clk) begin
    if (rst) begin
      cap      <= rcts_pkg::RCTS_IDLE;
      cap_cnt  <= '0;
      cap_trig <= 1'b0;
    end else if (trig_pulse) begin
      cap      <= rcts_pkg::RCTS_IDLE;
      cap_cnt  <= '0;
    end else if (start) begin
      cap      <= rcts_pkg::RCTS_EXPOSE;
      cap_cnt  <= '0;
      cap_trig <= abort_end;
    end else begin
      case (cap)
        rcts_pkg::RCTS_EXPOSE: begin
          if (cap_cnt == 32'(EXPOSE_N - 1)) begin
            cap     <= rcts_pkg::RCTS_READ;
            cap_cnt <= '0;
          end else begin
            cap_cnt <= cap_cnt + 32'h1;
          end
        end
        rcts_pkg::RCTS_READ: begin
          // a stalled output loses pixels; counted as overflow
          if (rd_last) begin
            cap     <= rcts_pkg::RCTS_IDLE;
            cap_cnt <= '0;
          end else begin
            cap_cnt <= cap_cnt + 32'h1;
          end
        end
        default: begin
          cap_cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      expose_start <= 1'b0;
      frame_drop   <= 1'b0;
      overflow     <= 1'b0;
    end else begin
      expose_start <= start && !trig_pulse;
      frame_drop   <= trig_pulse && cap != rcts_pkg::RCTS_IDLE;
      overflow     <= push_valid && !push_ready && !trig_pulse;
    end
  end

  assign push_word.data = sensor_pix;
  assign push_word.sof  = cap_cnt == 32'h0;
  assign push_word.eof  = rd_last;
  assign push_word.trig = cap_trig;

  // ---------------------------------------------------------------
  // output buffer, one copy fanned out to every enabled stream
  // ---------------------------------------------------------------
  rcts_pkg::rcts_word_t fifo_word;
  logic                 fifo_valid;
  logic                 fifo_take;

  rcts_fifo #(
    .WIDTH ($bits(rcts_pkg::rcts_word_t)),
    .DEPTH (rcts_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (flush),
    .in_data   (push_word),
    .in_valid  (push_valid && !trig_pulse),
    .in_ready  (push_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // registered output stage; all streams share one ready
  assign fifo_take = fifo_valid && (out_valid == '0 || out_ready);

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      out_valid <= '0;
      out_word  <= '0;
    end else if (fifo_take) begin
      out_valid <= stream_en;
      out_word  <= fifo_word;
    end else if (out_ready) begin
      out_valid <= '0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_abort_length: assert property (@(posedge clk) disable iff (rst)
    $rose(abort_active) |-> abort_active [*8])
    else $error("abort ended too early");

  a_abort_start: assert property (@(posedge clk) disable iff (rst)
    trig_pulse |=> abort_active && cap == rcts_pkg::RCTS_IDLE)
    else $error("trigger did not abort capture");

  a_trig_expose: assert property (@(posedge clk) disable iff (rst)
    abort_end && !trig_pulse |=> cap == rcts_pkg::RCTS_EXPOSE && cap_trig)
    else $error("triggered exposure not started");

  a_resume_gap: assert property (@(posedge clk) disable iff (rst)
    $fell(abort_active) |-> !frame_tick [*2])
    else $error("internal timing resumed too soon");

  a_edge_once: assert property (@(posedge clk) disable iff (rst)
    hit != '0 |=> (hit & $past(hit)) == '0)
    else $error("held level fired twice");

  a_drop_flush: assert property (@(posedge clk) disable iff (rst)
    trig_pulse |=> out_valid == '0 && !fifo_valid)
    else $error("aborted words not discarded");

  a_stream_all: assert property (@(posedge clk) disable iff (rst)
    fifo_take && !flush |=> out_valid == $past(stream_en))
    else $error("word not sent on every enabled stream");

  a_edge_polar: assert property (@(posedge clk) disable iff (rst)
    trig_en[0] && !trig_invert[0] && !prev[0] && sync2[0] |-> trig_pulse)
    else $error("rising edge missed");

  a_free_run: assert property (@(posedge clk) disable iff (rst)
    frame_tick && !trig_pulse |=> cap == rcts_pkg::RCTS_EXPOSE)
    else $error("internal exposure not started");
endmodule
`default_nettype wire

// file: bench/rcts_trig_src.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// external trigger source: pulses one port away from its idle level
// ---------------------------------------------------------------
module rcts_trig_src #(
  parameter int unsigned   N   = 4,
  parameter logic [N-1:0]  INV = '0
) (
  input  wire logic         clk,
  output var  logic [N-1:0] pin
);
  int cnt [N];

  // inverted ports rest high, so their trigger is the falling edge
  initial begin
    pin = INV;
    foreach (cnt[i]) cnt[i] = 0;
  end

  task automatic fire(input int p, input int hold);
    pin[p] = ~INV[p];
    cnt[p] = hold;
  endtask

  // release back to idle is the opposite edge and must not trigger
  always begin
    @(posedge clk);
    #1;
    foreach (cnt[i]) begin
      if (cnt[i] > 0) begin
        cnt[i]--;
        if (cnt[i] == 0) pin[i] = INV[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/realtime_capture_trigger_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module realtime_capture_trigger_sequencer_test;
  localparam int         AB    = 20;
  localparam int         FR    = 100;
  localparam int         EX    = 5;
  localparam int         RD    = 10;
  localparam int         LIMIT = 4000;
  localparam logic [3:0] INV   = 4'hA;
  logic                 clk, rst, out_ready, stall;
  logic                 expose_start, abort_active, frame_drop, overflow;
  logic [3:0]           trig_pin;
  logic [2:0]           stream_en, out_valid;
  logic [15:0]          sensor_pix, lfsr, prev_pix;
  rcts_pkg::rcts_word_t out_word;
  int                   failures, n_tests, cyc, nxt, wc, ovf, n_ovf;
  int                   n_drop, n_trig, exp_drop, exp_trig;
  int                   exp_q [$];

  // port 3 stays disabled to show that its edges are ignored
  rcts_seq #(.ABORT_N(AB), .FRAME_N(FR), .EXPOSE_N(EX), .READ_N(RD))
  i_rcts_seq (
    .clk(clk), .rst(rst), .trig_pin(trig_pin), .trig_en(4'h7),
    .trig_invert(INV), .stream_en(stream_en), .sensor_pix(sensor_pix),
    .expose_start(expose_start), .abort_active(abort_active),
    .frame_drop(frame_drop), .out_valid(out_valid), .out_word(out_word),
    .out_ready(out_ready), .overflow(overflow));
  rcts_trig_src #(.N(4), .INV(INV)) i_rcts_trig_src (
    .clk(clk), .pin(trig_pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_start;
    do step(1); while (expose_start !== 1'b1);
  endtask

  task automatic fire(input int p, input int h);
    int k;
    k = cyc;
    i_rcts_trig_src.fire(p, h);
    if (p == 3) begin
      step(10);
      check(abort_active, 0);
    end else begin
      // pin moves in cycle k, pulse at k+2, abort k+3 .. k+2+AB
      exp_q.push_back(k + AB + 3);
      exp_trig++;
      step(10);
      check(abort_active, 1);
      check(out_valid, 0);
      step(AB - 8);
      check(abort_active, 1);
      step(1);
      check(abort_active, 0);
    end
  endtask

  // ---------------------------------------------------------------
  // stimulus: random pixels and ready, plus the scenario sequence
  // ---------------------------------------------------------------
  always begin
    @(posedge clk);
    #1;
    lfsr = lfsr_step(lfsr);
    sensor_pix = lfsr;
    out_ready = ~stall & (lfsr[3:0] != 4'h0);
  end

  initial begin
    int         pt [6] = '{0, 1, 2, 3, 1, 0};
    int         wt [6] = '{6, 2, 40, 30, 60, 3};
    int         hd [6] = '{60, 3, 5, 4, 6, 8};
    logic [2:0] se [6] = '{3'h7, 3'h1, 3'h6, 3'h2, 3'h5, 3'h3};
    rst = 1'b1;
    stall = 1'b0;
    stream_en = 3'h7;
    sensor_pix = 16'h0000;
    out_ready = 1'b0;
    lfsr = 16'h0063;
    step(10);
    rst = 1'b0;
    // a long hold on the first one must not restart the abort
    foreach (pt[i]) begin
      wait_start();
      stream_en = se[i];
      step(wt[i]);
      if (pt[i] != 3 && wt[i] + 2 < EX + RD) exp_drop++;
      fire(pt[i], hd[i]);
    end
    wait_start();
    step(40);
    i_rcts_trig_src.fire(0, 3);
    step(8);
    fire(2, 4);
    wait_start();
    stall = 1'b1;
    step(130);
    stall = 1'b0;
    check(n_ovf != 0, 1);
    step(40);
    check(out_valid, 0);
    step(FR);
    check(n_drop, exp_drop);
    check(n_trig, exp_trig);
    test_done();
  end

  // ---------------------------------------------------------------
  // monitor: exposure timing, drops and delivered words
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      test_done();
    end
    if (rst === 1'b0) begin
      if (frame_drop === 1'b1) n_drop++;
      if (overflow === 1'b1) begin
        ovf++;
        n_ovf++;
      end
      if (expose_start === 1'b1) begin
        if (exp_q.size() > 0) check(cyc, exp_q.pop_front());
        else if (nxt > 0) check(cyc, nxt);
        nxt = cyc + FR;
        ovf = 0;
      end
      if ((|out_valid) === 1'b1 && out_ready) begin
        check(out_valid, stream_en);
        // pixels of one frame are successive lfsr states
        if (out_word.sof === 1'b1) wc = 0;
        else if (ovf == 0) check(out_word.data, lfsr_step(prev_pix));
        prev_pix = out_word.data;
        wc++;
        if (out_word.eof === 1'b1) begin
          if (ovf == 0) check(wc, RD);
          if (out_word.trig === 1'b1) n_trig++;
        end
      end
    end
  end
endmodule
`default_nettype wire
